// [include/bfb_pkg.sv]
// Types shared by the boot flash bus host modules.
package bfb_pkg;
  typedef enum logic [2:0] {
    BFB_OP_READ,
    BFB_OP_PROGRAM,
    BFB_OP_ERASE,
    BFB_OP_READ_ARRAY,
    BFB_OP_IDENT_CMD,
    BFB_OP_IDENT_HV
  } bfb_op_t;
  typedef enum logic [2:0] {
    BFB_ST_RESET,
    BFB_ST_IDLE,
    BFB_ST_SETUP,
    BFB_ST_STROBE,
    BFB_ST_HOLD,
    BFB_ST_GAP
  } bfb_state_t;
endpackage : bfb_pkg

// [include/bfb_regs.svh]
// Command codes, timing figures and pin positions for the boot flash bus host.
`ifndef BFB_REGS_SVH
`define BFB_REGS_SVH
`define BFB_CMD_ERASE_SETUP 8'h20
`define BFB_CMD_ERASE_CONFIRM 8'hd0
`define BFB_CMD_WRITE_SETUP 8'h40
`define BFB_CMD_READ_ARRAY 8'hff
`define BFB_CMD_IDENTIFY 8'h90
`define BFB_CLK_MHZ 40
`define BFB_ACCESS_NS 100
`define BFB_WE_LOW_NS 50
`define BFB_RP_LOW_NS 100
`define BFB_SYNC_STAGES 2
`define BFB_MIN_CYC(ns) ((((ns) * `BFB_CLK_MHZ) + 999) / 1000)
`define BFB_ADDR_PINS 18
`define BFB_TOP_DQ 15
`endif

// [logic/bfb_cycle_timer.sv]
// Down counter that times one strobe phase of a flash bus cycle.
`timescale 1ns/100ps
`default_nettype none
module bfb_cycle_timer (
  input wire logic ref_clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic load, // Load the count.
  input wire logic [7:0] loadVal, // Cycles left after the load cycle.
  output logic done // Count has reached zero.
);
  logic [7:0] count_r;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      count_r <= 8'h00;
    end else if (load) begin
      count_r <= loadVal;
    end else if (count_r != 8'h00) begin
      count_r <= count_r - 8'h01;
    end
  end

  assign done = (count_r == 8'h00);
endmodule : bfb_cycle_timer
`default_nettype wire

// [logic/bfb_host.sv]
// Host controller that drives a boot-block flash through its parallel bus pins.
`timescale 1ns/100ps
`default_nettype none
`include "bfb_regs.svh"
module bfb_host (
  input wire logic ref_clk, // System clock, 40 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic cmdValid, // Request valid.
  output logic cmdReady, // Request accepted when valid and ready.
  input wire bfb_pkg::bfb_op_t cmdOp, // Operation.
  input wire logic [18:0] cmdAddr, // Word address, or byte address in byte mode.
  input wire logic [15:0] cmdData, // Program data.
  input wire logic cmdBoot, // Target is the boot block.
  input wire logic cmdUseHv, // Unlock boot block by high voltage on reset pin.
  input wire logic wordMode, // Bus width, high for word mode.
  output logic rspValid, // One-cycle pulse with read data.
  output logic [15:0] rspData, // Read data.
  output logic chipSelN, // Chip select pin, active low.
  output logic outEnN, // Output enable pin, active low.
  output logic writeStrobeN, // Write strobe pin, active low.
  output logic reset_powerdown_n, // Reset and power-down pin, active low.
  output logic rpHighVoltage, // Raise reset pin to the high voltage level.
  output logic bootUnlock, // Boot unlock pin.
  output logic idVoltage, // Raise address pin 9 to the identification voltage.
  output logic widthSel, // Width select pin, high for word mode.
  output logic [17:0] addrPins, // Address pins.
  output logic [15:0] dqOut, // Data pin output values.
  output logic [15:0] dqOeN, // Data pin output enables, low drives.
  input wire logic [15:0] dqIn // Data pin levels.
);
  import bfb_pkg::*;

  localparam logic [7:0] RdCyc = 8'(`BFB_MIN_CYC(`BFB_ACCESS_NS) + `BFB_SYNC_STAGES);
  localparam logic [7:0] WeCyc = 8'(`BFB_MIN_CYC(`BFB_WE_LOW_NS));
  localparam logic [7:0] RpCyc = 8'(`BFB_MIN_CYC(`BFB_RP_LOW_NS));

  bfb_state_t state_r;
  bfb_op_t op_r;
  logic [18:0] addr_r;
  logic [15:0] cycData_r [2];
  logic [1:0] cycRead_r;
  logic lastIdx_r;
  logic cycIdx_r;
  logic boot_r;
  logic useHv_r;
  logic word_r;
  logic needArr_r;
  logic [7:0] rpCnt_r;
  logic [15:0] dqSync1_r;
  logic [15:0] dqSync2_r;
  logic [7:0] lastWr_r;
  logic timerDone;
  logic curRead;
  logic lastCyc;
  logic idRead;
  logic busy;

  function automatic logic [15:0] cmdWord(input logic [7:0] code);
    cmdWord = {8'h00, code};
  endfunction : cmdWord

  assign curRead = cycRead_r[cycIdx_r];
  assign lastCyc = (cycIdx_r == lastIdx_r);
  assign idRead = (op_r == BFB_OP_IDENT_CMD) || (op_r == BFB_OP_IDENT_HV);
  assign busy = (state_r == BFB_ST_SETUP) || (state_r == BFB_ST_STROBE)
                || (state_r == BFB_ST_HOLD);

  bfb_cycle_timer bfb_cycle_timer_inst (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .load(state_r == BFB_ST_SETUP),
    .loadVal((curRead ? RdCyc : WeCyc) - 8'h01),
    .done(timerDone)
  );

  // Pin levels are sampled twice before use since the flash is outside this clock.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dqSync1_r <= 16'h0000;
      dqSync2_r <= 16'h0000;
    end else begin
      dqSync1_r <= dqIn;
      dqSync2_r <= dqSync1_r;
    end
  end

  // Sequencer: each request becomes one or two bus cycles.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= BFB_ST_RESET;
      rpCnt_r <= RpCyc;
      op_r <= BFB_OP_READ;
      addr_r <= 19'h00000;
      cycData_r[0] <= 16'h0000;
      cycData_r[1] <= 16'h0000;
      cycRead_r <= 2'h0;
      lastIdx_r <= 1'b0;
      cycIdx_r <= 1'b0;
      boot_r <= 1'b0;
      useHv_r <= 1'b0;
      word_r <= 1'b1;
    end else begin
      unique case (state_r)
        BFB_ST_RESET: begin
          rpCnt_r <= rpCnt_r - 8'h01;
          if (rpCnt_r == 8'h01) begin
            state_r <= BFB_ST_IDLE;
          end
        end
        BFB_ST_IDLE: begin
          if (cmdValid) begin
            op_r <= cmdOp;
            addr_r <= cmdAddr;
            boot_r <= cmdBoot;
            useHv_r <= cmdUseHv;
            word_r <= wordMode;
            cycIdx_r <= 1'b0;
            state_r <= BFB_ST_SETUP;
            unique case (cmdOp)
              BFB_OP_READ: begin
                cycData_r[0] <= cmdWord(`BFB_CMD_READ_ARRAY);
                cycRead_r <= needArr_r ? 2'b10 : 2'b01;
                lastIdx_r <= needArr_r;
              end
              BFB_OP_PROGRAM: begin
                cycData_r[0] <= cmdWord(`BFB_CMD_WRITE_SETUP);
                cycData_r[1] <= wordMode ? cmdData : {8'h00, cmdData[7:0]};
                cycRead_r <= 2'b00;
                lastIdx_r <= 1'b1;
              end
              BFB_OP_ERASE: begin
                cycData_r[0] <= cmdWord(`BFB_CMD_ERASE_SETUP);
                cycData_r[1] <= cmdWord(`BFB_CMD_ERASE_CONFIRM);
                cycRead_r <= 2'b00;
                lastIdx_r <= 1'b1;
              end
              BFB_OP_READ_ARRAY: begin
                cycData_r[0] <= cmdWord(`BFB_CMD_READ_ARRAY);
                cycRead_r <= 2'b00;
                lastIdx_r <= 1'b0;
              end
              BFB_OP_IDENT_CMD: begin
                cycData_r[0] <= cmdWord(`BFB_CMD_IDENTIFY);
                cycRead_r <= 2'b10;
                lastIdx_r <= 1'b1;
              end
              BFB_OP_IDENT_HV: begin
                cycRead_r <= 2'b01;
                lastIdx_r <= 1'b0;
              end
            endcase
          end
        end
        BFB_ST_SETUP: state_r <= BFB_ST_STROBE;
        BFB_ST_STROBE: begin
          if (timerDone) begin
            state_r <= BFB_ST_HOLD;
          end
        end
        BFB_ST_HOLD: state_r <= BFB_ST_GAP;
        BFB_ST_GAP: begin
          if (lastCyc) begin
            state_r <= BFB_ST_IDLE;
          end else begin
            cycIdx_r <= 1'b1;
            state_r <= BFB_ST_SETUP;
          end
        end
      endcase
    end
  end

  // Tracks whether the flash has left array-read mode.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      needArr_r <= 1'b0;
    end else if (state_r == BFB_ST_GAP && lastCyc) begin
      if (op_r == BFB_OP_READ || op_r == BFB_OP_READ_ARRAY) begin
        needArr_r <= 1'b0;
      end else if (op_r != BFB_OP_IDENT_HV) begin
        needArr_r <= 1'b1;
      end
    end
  end

  // Read capture; sampling ends the strobe after access time plus sync delay.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rspValid <= 1'b0;
      rspData <= 16'h0000;
    end else begin
      rspValid <= (state_r == BFB_ST_STROBE) && timerDone && curRead;
      if ((state_r == BFB_ST_STROBE) && timerDone && curRead) begin
        rspData <= word_r ? dqSync2_r : {8'h00, dqSync2_r[7:0]};
      end
    end
  end

  // Last written low byte, watched by the checks below.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lastWr_r <= 8'h00;
    end else if (state_r == BFB_ST_HOLD && !curRead) begin
      lastWr_r <= dqOut[7:0];
    end
  end

  // Pin decode; data driven only while selected, writing, outputs off; in byte mode DQ15 is driven while selected, with byte address bit or 0 on id reads.
  always_comb begin
    cmdReady = (state_r == BFB_ST_IDLE);
    reset_powerdown_n = (state_r != BFB_ST_RESET);
    chipSelN = !busy;
    writeStrobeN = !((state_r == BFB_ST_STROBE) && !curRead);
    outEnN = !((state_r == BFB_ST_STROBE) && curRead);
    widthSel = word_r;
    idVoltage = busy && (op_r == BFB_OP_IDENT_HV);
    bootUnlock = busy && boot_r && !useHv_r && lastCyc;
    rpHighVoltage = busy && boot_r && useHv_r && lastCyc;
    if (idRead && curRead) begin
      addrPins = 18'(word_r ? addr_r[0] : addr_r[1]);
    end else if (word_r) begin
      addrPins = addr_r[17:0];
    end else begin
      addrPins = addr_r[18:1];
    end
    dqOut = cycData_r[cycIdx_r];
    dqOeN = 16'hffff;
    if (busy && !curRead) begin
      dqOeN[7:0] = 8'h00;
      if (word_r) begin
        dqOeN[15:8] = 8'h00;
      end
    end
    if (busy && !word_r) begin
      dqOut[`BFB_TOP_DQ] = (idRead && curRead) ? 1'b0 : addr_r[0];
      dqOeN[`BFB_TOP_DQ] = 1'b0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence erase_setup_s;
    $rose(writeStrobeN) && !cycIdx_r && (dqOut[7:0] == `BFB_CMD_ERASE_SETUP);
  endsequence
  sequence erase_confirm_s;
    $rose(writeStrobeN) && (op_r == BFB_OP_ERASE) && cycIdx_r;
  endsequence

  byte_float_a: assert property (!widthSel |-> &dqOeN[14:8])
    else $error("upper data pins driven in byte mode");
  word_upper_a: assert property (widthSel && !dqOeN[0] |-> dqOeN[15:8] == 8'h00)
    else $error("upper byte not driven in word write");
  erase_order_a: assert property (erase_confirm_s |->
      (dqOut[7:0] == `BFB_CMD_ERASE_CONFIRM) && (lastWr_r == `BFB_CMD_ERASE_SETUP))
    else $error("erase confirm not after setup");
  erase_setup_a: assert property (erase_setup_s and (op_r == BFB_OP_ERASE)
      |-> ##[1:20] erase_confirm_s)
    else $error("erase setup not followed by confirm");
  prog_setup_a: assert property ($rose(writeStrobeN) && op_r == BFB_OP_PROGRAM
      && cycIdx_r |-> lastWr_r == `BFB_CMD_WRITE_SETUP)
    else $error("program data not after setup");
  deselect_float_a: assert property (chipSelN |-> &dqOeN)
    else $error("data pins driven while deselected");
  read_float_a: assert property (!outEnN |-> &dqOeN[14:0] && (!widthSel || dqOeN[15]))
    else $error("host drives data while flash outputs");
  strobe_excl_a: assert property (!writeStrobeN |-> outEnN && !chipSelN)
    else $error("write strobe with output enable");
  we_first_a: assert property ($rose(writeStrobeN) |-> !chipSelN ##1 chipSelN)
    else $error("chip select not held past write strobe");
  array_first_a: assert property ($fell(outEnN) && op_r == BFB_OP_READ
      |-> !needArr_r || cycIdx_r)
    else $error("array read without read-array command");
  boot_unlock_a: assert property ($rose(writeStrobeN) && boot_r && cycIdx_r
      |-> $past(bootUnlock || rpHighVoltage))
    else $error("boot block change without unlock");
  id_addr_a: assert property (!outEnN && idRead |-> addrPins[17:1] == 17'h00000)
    else $error("identification read with address lines high");
  powerdown_idle_a: assert property (!reset_powerdown_n |-> chipSelN && writeStrobeN)
    else $error("bus active during power-down");
endmodule : bfb_host
`default_nettype wire

// [test/bfb_flash_model.sv]
// Behavioural boot-block flash that answers the host pins.
`timescale 1ns/100ps
`default_nettype none
module bfb_flash_model #(
  parameter logic [15:0] MFR_ID = 16'h115a, // Arbitrary value.
  parameter logic [15:0] DEV_ID = 16'h3ca6, // Arbitrary value.
  parameter int BOOT_BYTES = 16384 // Bottom boot block size.
) (
  input wire logic chipSelN, // Chip select.
  input wire logic outEnN, // Output enable.
  input wire logic writeStrobeN, // Write strobe.
  input wire logic reset_powerdown_n, // Reset pin.
  input wire logic rpHighVoltage, // Reset pin at high voltage.
  input wire logic bootUnlock, // Boot unlock pin.
  input wire logic idVoltage, // Id voltage on address pin 9.
  input wire logic widthSel, // Word mode.
  input wire logic [17:0] addrPins, // Address pins.
  input wire logic [15:0] dqOut, // Host data.
  input wire logic [15:0] dqOeN, // Host enables, low drives.
  output logic [15:0] dqIn // Pin levels.
);
  logic [7:0] mem [int];
  logic [7:0] cmdLog [$];
  logic [2:0] mode = 3'h0; // 0 array, 1 ident, 2 erase setup, 3 write setup, 4 status.
  logic [15:0] devVal;
  logic devOn;
  int addr;
  assign devOn = reset_powerdown_n && !chipSelN && !outEnN && writeStrobeN;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd
  function automatic logic unlocked();
    return addr >= BOOT_BYTES || rpHighVoltage || bootUnlock;
  endfunction : unlocked
  // A released pin shows the inverse of the host value, so stale data never reads as valid.
  always @* begin
    addr = widthSel ? int'({addrPins, 1'b0}) : int'({addrPins, dqOut[15]});
    devVal = (mode == 3'h4) ? 16'h0080 : {rd(addr + 1), rd(addr)};
    if (idVoltage || mode == 3'h1) devVal = addrPins[0] ? DEV_ID : MFR_ID;
    for (int i = 0; i < 16; i++) begin
      dqIn[i] = dqOeN[i] ? ~dqOut[i] : dqOut[i];
      if (dqOeN[i] && devOn && (widthSel || i < 8)) dqIn[i] = devVal[i];
    end
  end
  task automatic take();
    logic [7:0] c;
    c = dqIn[7:0];
    cmdLog.push_back(c);
    if (mode == 3'h3 && unlocked()) mem[addr] = c;
    if (mode == 3'h3 && unlocked() && widthSel) mem[addr + 1] = dqIn[15:8];
    // Erase clears the whole array; block bounds are not needed by the bench.
    if (mode == 3'h2 && c == 8'hd0 && unlocked()) mem.delete();
    if (mode == 3'h2 || mode == 3'h3) mode = 3'h4;
    else if (c == 8'h20) mode = 3'h2;
    else if (c == 8'h10 || c == 8'h40) mode = 3'h3;
    else if (c == 8'h90) mode = 3'h1;
    else if (c == 8'hff) mode = 3'h0;
  endtask : take
  always @(posedge writeStrobeN) if (reset_powerdown_n && !chipSelN) take();
  always @(posedge chipSelN) if (reset_powerdown_n && !writeStrobeN) take();
  always @(negedge reset_powerdown_n) mode = 3'h0;
endmodule : bfb_flash_model
`default_nettype wire

// [test/bfb_host_bench.sv]
// Self-checking bench: host controller driving a behavioural flash.
`timescale 1ns/100ps
`default_nettype none
module bfb_host_bench;
  import bfb_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmdValid = 1'b0;
  bfb_op_t cmdOp = BFB_OP_READ;
  logic [18:0] cmdAddr = 19'h0;
  logic [15:0] cmdData = 16'h0;
  logic cmdBoot = 1'b0;
  logic cmdUseHv = 1'b0;
  logic wordMode = 1'b1;
  logic cmdReady, rspValid, chipSelN, outEnN, writeStrobeN, reset_powerdown_n;
  logic rpHighVoltage, bootUnlock, idVoltage, widthSel;
  logic [15:0] rspData, dqOut, dqOeN, dqIn;
  logic [17:0] addrPins;
  int n_mismatch = 0;
  int checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  bfb_host bfb_host_inst (.ref_clk, .reset_n, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdData,
    .cmdBoot, .cmdUseHv, .wordMode, .rspValid, .rspData, .chipSelN, .outEnN, .writeStrobeN,
    .reset_powerdown_n, .rpHighVoltage, .bootUnlock, .idVoltage, .widthSel, .addrPins, .dqOut,
    .dqOeN, .dqIn);
  bfb_flash_model bfb_flash_model_inst (.chipSelN, .outEnN, .writeStrobeN, .reset_powerdown_n,
    .rpHighVoltage, .bootUnlock, .idVoltage, .widthSel, .addrPins, .dqOut, .dqOeN, .dqIn);
  task automatic check(string what, logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic issue(bfb_op_t op, logic [18:0] a, logic [15:0] d, logic boot, logic hv,
    logic wm);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (cmdReady !== 1'b1 && n < 100) begin
      n++;
      @(negedge ref_clk);
    end
    check("ready", 16'(cmdReady), 16'h1);
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    cmdBoot = boot;
    cmdUseHv = hv;
    wordMode = wm;
    cmdValid = 1'b1;
    @(negedge ref_clk);
    cmdValid = 1'b0;
  endtask : issue
  task automatic readChk(string what, bfb_op_t op, logic [18:0] a, logic wm, logic [15:0] exp);
    int n;
    n = 0;
    issue(op, a, 16'h0, 1'b0, 1'b0, wm);
    while (rspValid !== 1'b1 && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
    check("answer", 16'(rspValid), 16'h1);
    check(what, wm ? rspData : 16'(rspData[7:0]), exp);
  endtask : readChk
  task automatic logChk(logic [7:0] e [$]);
    check("log size", 16'(bfb_flash_model_inst.cmdLog.size()), 16'(e.size()));
    foreach (e[i]) check("log byte", 16'(bfb_flash_model_inst.cmdLog[i]), 16'(e[i]));
    bfb_flash_model_inst.cmdLog.delete();
  endtask : logChk
  always @(negedge ref_clk) begin
    if (reset_n) begin
      if (!writeStrobeN) check("write strobes", 16'({chipSelN, outEnN}), 16'h1);
      if (!outEnN) check("read strobes", 16'({chipSelN, writeStrobeN}), 16'h1);
      if (chipSelN) check("deselected pins", dqOeN, 16'hffff);
      if (!widthSel) check("upper pins", 16'(dqOeN[14:8]), 16'h7f);
      if (idVoltage) check("id address", 16'(|addrPins[17:1]), 16'h0);
      if (!reset_powerdown_n) check("idle strobes", 16'({chipSelN, writeStrobeN}), 16'h3);
      if (!writeStrobeN) check("low pins driven", 16'(dqOeN[7:0]), 16'h0);
      if (bootUnlock || rpHighVoltage) check("unlock use", 16'(cmdBoot), 16'h1);
    end
  end
  task automatic progRead();
    issue(BFB_OP_PROGRAM, 19'h10100, 16'ha5c3, 1'b0, 1'b0, 1'b1);
    readChk("word read", BFB_OP_READ, 19'h10100, 1'b1, 16'ha5c3);
    logChk('{8'h40, 8'hc3, 8'hff});
  endtask : progRead
  task automatic byteRead();
    issue(BFB_OP_PROGRAM, 19'h20403, 16'h007e, 1'b0, 1'b0, 1'b0);
    readChk("byte read", BFB_OP_READ, 19'h20403, 1'b0, 16'h007e);
    readChk("next byte", BFB_OP_READ, 19'h20402, 1'b0, 16'h00ff);
    readChk("whole word", BFB_OP_READ, 19'h10201, 1'b1, 16'h7eff);
    logChk('{8'h40, 8'h7e, 8'hff});
  endtask : byteRead
  task automatic eraseBlock();
    issue(BFB_OP_ERASE, 19'h10100, 16'h0, 1'b0, 1'b0, 1'b1);
    readChk("erased word", BFB_OP_READ, 19'h10100, 1'b1, 16'hffff);
    logChk('{8'h20, 8'hd0, 8'hff});
  endtask : eraseBlock
  task automatic bootWrites();
    issue(BFB_OP_PROGRAM, 19'h00010, 16'h1234, 1'b1, 1'b0, 1'b1);
    issue(BFB_OP_PROGRAM, 19'h00020, 16'h5678, 1'b1, 1'b1, 1'b1);
    readChk("boot by pin", BFB_OP_READ, 19'h00010, 1'b1, 16'h1234);
    readChk("boot by voltage", BFB_OP_READ, 19'h00020, 1'b1, 16'h5678);
    logChk('{8'h40, 8'h34, 8'h40, 8'h78, 8'hff});
  endtask : bootWrites
  task automatic identRead();
    readChk("maker word", BFB_OP_IDENT_HV, 19'h00000, 1'b1, 16'h115a);
    readChk("device word", BFB_OP_IDENT_HV, 19'h00001, 1'b1, 16'h3ca6);
    readChk("device byte", BFB_OP_IDENT_HV, 19'h00002, 1'b0, 16'h00a6);
    readChk("device by cmd", BFB_OP_IDENT_CMD, 19'h00001, 1'b1, 16'h3ca6);
    readChk("array again", BFB_OP_READ, 19'h00010, 1'b1, 16'h1234);
    logChk('{8'h90, 8'hff});
  endtask : identRead
  initial begin
    repeat (16) @(negedge ref_clk);
    check("reset pin", 16'(reset_powerdown_n), 16'h0);
    check("pins released", dqOeN, 16'hffff);
    reset_n = 1'b1;
    progRead();
    byteRead();
    eraseBlock();
    bootWrites();
    identRead();
    summarize();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end
endmodule : bfb_host_bench
`default_nettype wire
